/* File: logic/range_monitor_pkg.sv */
// Constants used by the range access monitor; its match slice uses none of them.
// Assumes the register indices below sit on an AXI4-Lite bus at byte address 4 * index.
// Notes on behaviour
// - Base register holds A[8:1] or A[22:15]; control bit 7 adds A9 or A23.
// - Control bit 6 enables writes, bit 5 reads, bits 4:0 mask low address bits.
// - A set mask bit removes that base bit from the compare.
// - Feature register picks I/O or memory per monitor, holds A0/A14 bits; resets 03h.
// - Basic memory mode compares A[23:14], a 16KB smallest block.
// - Extension registers add base and mask bits for A[13:2], down to 4 bytes.
// - With extension in use, I/O compares all 16 bits unless upper bits masked.
// - Extension registers do nothing until one of them is written after reset.
// - Memory mode matches CPU cycles only, never other bus masters.
// - Without remap, memory decode covers 16MB and aliases above it.
// - Feature bits 7:6 remap each monitor's fine bits to A31, A25, A24.
// - In memory mode the read and write enables qualify memory cycles.
// - Each monitor drives its own access event output.

`default_nettype none

package range_monitor_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register indices (byte address = 4 * index)
	localparam logic [7:0] IDX_R1_BASE    = 8'h48;
	localparam logic [7:0] IDX_R1_CTL     = 8'h49;
	localparam logic [7:0] IDX_FEATURE    = 8'hae;
	localparam logic [7:0] IDX_R2_BASE    = 8'hb8;
	localparam logic [7:0] IDX_R2_CTL     = 8'hb9;
	localparam logic [7:0] IDX_EXT_FIRST  = 8'h70;
	localparam logic [7:0] IDX_EXT_LAST   = 8'h75;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'hc0;
	localparam logic [7:0] IDX_IRQ_MASK   = 8'hc1;
	localparam int unsigned EXT_PER_MON   = 3;
	localparam int unsigned EXT_COUNT     = 6;

	////////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [7:0] RST_BASE    = 8'h00;
	localparam logic [7:0] RST_CTL     = 8'h00;
	localparam logic [7:0] RST_FEATURE = 8'h03;
	localparam logic [7:0] RST_EXT     = 8'h00;
	localparam logic [1:0] RST_IRQ     = 2'h0;

	////////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int unsigned CTL_HI_BIT     = 7;
	localparam int unsigned CTL_WR_BIT     = 6;
	localparam int unsigned CTL_RD_BIT     = 5;
	localparam int unsigned CTL_MASK_W     = 5;
	localparam int unsigned FEAT_MASK_BIT0 = 0;
	localparam int unsigned FEAT_BASE_BIT0 = 2;
	localparam int unsigned FEAT_MEM_BIT0  = 4;
	localparam int unsigned FEAT_REMAP_BIT0 = 6;

	////////////////////////////////////////////////////////////////////////////////
	// Address bit positions
	localparam int unsigned IO_BASE_LSB     = 1;
	localparam int unsigned MEM_BASE_LSB    = 15;
	localparam int unsigned IO_UPPER_LSB    = 10;
	localparam int unsigned IO_UPPER_W      = 6;
	localparam int unsigned EXT_HI_LSB      = 6;
	localparam int unsigned EXT_LO_LSB      = 2;
	localparam int unsigned REMAP_TOP_BIT   = 31;
	localparam int unsigned REMAP_MID_BIT   = 25;
	localparam int unsigned REMAP_LOW_BIT   = 24;

	////////////////////////////////////////////////////////////////////////////////
	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

`default_nettype wire

/* File: logic/range_match.sv */
// One address-range compare slice: qualifies a bus cycle against a pattern.
// Assumes the cycle inputs come from logic on the same clock.

`default_nettype none

module range_match (
	// Pattern
	input  wire logic [31:0] want_i,
	input  wire logic [31:0] care_i,
	input  wire logic        mem_mode_i,
	input  wire logic        rd_en_i,
	input  wire logic        wr_en_i,
	// Bus cycle
	input  wire logic        cyc_valid_i,
	input  wire logic        cyc_write_i,
	input  wire logic        cyc_mem_i,
	input  wire logic        cyc_cpu_i,
	input  wire logic [31:0] cyc_addr_i,
	// Result
	output logic             match_o
);

	logic type_ok;
	logic dir_ok;
	logic addr_ok;

	assign type_ok = (cyc_mem_i == mem_mode_i) && (!cyc_mem_i || cyc_cpu_i);
	assign dir_ok  = cyc_write_i ? wr_en_i : rd_en_i;
	assign addr_ok = ((cyc_addr_i ^ want_i) & care_i) == 32'h0000_0000;
	assign match_o = cyc_valid_i && type_ok && dir_ok && addr_ok;

endmodule

`default_nettype wire

/* File: logic/range_access_monitor.sv */
// Two programmable address-range access monitors with an AXI4-Lite register slave.
// Assumes host bus cycle inputs are synchronous to clk_i, one cycle per valid pulse.

`default_nettype none

module range_access_monitor #(
	parameter int unsigned AXI_ADDR_W = 12
) (
	// Clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	// AXI4-Lite write
	input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr_i,
	input  wire logic                  s_axi_awvalid_i,
	output logic                       s_axi_awready_o,
	input  wire logic [31:0]           s_axi_wdata_i,
	input  wire logic [3:0]            s_axi_wstrb_i,
	input  wire logic                  s_axi_wvalid_i,
	output logic                       s_axi_wready_o,
	output logic [1:0]                 s_axi_bresp_o,
	output logic                       s_axi_bvalid_o,
	input  wire logic                  s_axi_bready_i,
	// AXI4-Lite read
	input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr_i,
	input  wire logic                  s_axi_arvalid_i,
	output logic                       s_axi_arready_o,
	output logic [31:0]                s_axi_rdata_o,
	output logic [1:0]                 s_axi_rresp_o,
	output logic                       s_axi_rvalid_o,
	input  wire logic                  s_axi_rready_i,
	// Host bus cycle
	input  wire logic                  cyc_valid_i,
	input  wire logic                  cyc_write_i,
	input  wire logic                  cyc_mem_i,
	input  wire logic                  cyc_cpu_i,
	input  wire logic [31:0]           cyc_addr_i,
	input  wire logic                  io_upper_zero_i,
	// Events
	output logic                       range_one_hit_event_o,
	output logic                       range_two_hit_event_o,
	output logic                       irq_o
);

	////////////////////////////////////////////////////////////////////////////////
	// Functions

	// Index of a word address; flag says it lands on a mapped register
	function automatic logic [8:0] decode(input logic [AXI_ADDR_W-1:0] a);
		logic [7:0] idx;
		logic       ok;
		idx = a[9:2];
		ok  = (a[1:0] == 2'h0) && (a[AXI_ADDR_W-1:10] == '0);
		ok  = ok && (idx == range_monitor_pkg::IDX_R1_BASE || idx == range_monitor_pkg::IDX_R1_CTL
			|| idx == range_monitor_pkg::IDX_FEATURE || idx == range_monitor_pkg::IDX_R2_BASE
			|| idx == range_monitor_pkg::IDX_R2_CTL || idx == range_monitor_pkg::IDX_IRQ_STATUS
			|| idx == range_monitor_pkg::IDX_IRQ_MASK
			|| (idx >= range_monitor_pkg::IDX_EXT_FIRST && idx <= range_monitor_pkg::IDX_EXT_LAST));
		return {ok, idx};
	endfunction

	// Builds {want, care} for one monitor from its register fields
	function automatic logic [63:0] build(
		input logic       mem,
		input logic [7:0] base,
		input logic [7:0] ctl,
		input logic       fbase,
		input logic       fmask,
		input logic       ext_on,
		input logic [7:0] hi_base,
		input logic [7:0] hi_mask,
		input logic [7:0] lo,
		input logic       remap,
		input logic       upper_zero
	);
		logic [31:0] w;
		logic [31:0] c;
		int unsigned l;
		w = 32'h0000_0000;
		c = 32'h0000_0000;
		l = mem ? range_monitor_pkg::MEM_BASE_LSB : range_monitor_pkg::IO_BASE_LSB;
		// Ten-bit window, A[9:0] or A[23:14]
		w[l +: 8] = base;
		w[l + 8]  = ctl[range_monitor_pkg::CTL_HI_BIT];
		w[l - 1]  = fbase;
		c[l - 1 +: 10] = 10'h3ff;
		c[l +: range_monitor_pkg::CTL_MASK_W] = ~ctl[range_monitor_pkg::CTL_MASK_W-1:0];
		c[l - 1] = ~fmask;
		if (mem && ext_on) begin
			// Fine granularity down to four bytes
			w[range_monitor_pkg::EXT_HI_LSB +: 8] = hi_base;
			c[range_monitor_pkg::EXT_HI_LSB +: 8] = ~hi_mask;
			if (remap) begin
				w[range_monitor_pkg::REMAP_TOP_BIT] = lo[7];
				w[range_monitor_pkg::REMAP_MID_BIT] = lo[5];
				w[range_monitor_pkg::REMAP_LOW_BIT] = lo[4];
				c[range_monitor_pkg::REMAP_TOP_BIT] = ~lo[3];
				c[range_monitor_pkg::REMAP_MID_BIT] = ~lo[1];
				c[range_monitor_pkg::REMAP_LOW_BIT] = ~lo[0];
			end else begin
				w[range_monitor_pkg::EXT_LO_LSB +: 4] = lo[7:4];
				c[range_monitor_pkg::EXT_LO_LSB +: 4] = ~lo[3:0];
			end
		end else if (!mem && ext_on) begin
			// Extension wins over the global ten-bit decode option
			w[range_monitor_pkg::IO_UPPER_LSB +: range_monitor_pkg::IO_UPPER_W] =
				hi_base[range_monitor_pkg::IO_UPPER_W-1:0];
			c[range_monitor_pkg::IO_UPPER_LSB +: range_monitor_pkg::IO_UPPER_W] =
				~hi_mask[range_monitor_pkg::IO_UPPER_W-1:0];
		end else if (!mem && upper_zero) begin
			c[range_monitor_pkg::IO_UPPER_LSB +: range_monitor_pkg::IO_UPPER_W] = 6'h3f;
		end
		// Bits above A23 stay don't-care unless remapped: 16MB aliasing
		return {w, c};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Registers

	logic [7:0]            base_q [2];
	logic [7:0]            ctl_q  [2];
	logic [7:0]            ext_q  [range_monitor_pkg::EXT_COUNT];
	logic [7:0]            feature_q;
	logic                  ext_written;
	logic [1:0]            irq_status;
	logic [1:0]            irq_mask;
	logic [1:0]            hit_q;
	logic [1:0]            match;
	logic                  aw_full;
	logic                  w_full;
	logic [AXI_ADDR_W-1:0] awaddr_q;
	logic [31:0]           wdata_q;
	logic                  wstrb0_q;
	logic                  do_write;
	logic                  reg_wr;
	logic [8:0]            wdec;
	logic [8:0]            rdec;
	logic                  next_aw_full;
	logic                  next_w_full;
	logic [1:0]            next_irq_status;
	logic [1:0]            w1c;

	assign do_write     = aw_full && w_full && !s_axi_bvalid_o;
	// Unmapped or misaligned writes answer SLVERR and must change nothing
	assign reg_wr       = do_write && wstrb0_q && wdec[8];
	assign wdec         = decode(awaddr_q);
	assign rdec         = decode(s_axi_araddr_i);
	assign next_aw_full = (aw_full && !do_write) || (s_axi_awvalid_i && s_axi_awready_o);
	assign next_w_full  = (w_full && !do_write) || (s_axi_wvalid_i && s_axi_wready_o);

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write channels

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			aw_full         <= 1'b0;
			w_full          <= 1'b0;
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o  <= 1'b1;
			awaddr_q        <= '0;
			wdata_q         <= 32'h0000_0000;
			wstrb0_q        <= 1'b0;
		end else begin
			aw_full         <= next_aw_full;
			w_full          <= next_w_full;
			s_axi_awready_o <= !next_aw_full;
			s_axi_wready_o  <= !next_w_full;
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				awaddr_q <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				wdata_q  <= s_axi_wdata_i;
				wstrb0_q <= s_axi_wstrb_i[0];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= range_monitor_pkg::RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid_o <= 1'b1;
			s_axi_bresp_o  <= wdec[8] ? range_monitor_pkg::RESP_OKAY : range_monitor_pkg::RESP_SLVERR;
		end else if (s_axi_bready_i) begin
			s_axi_bvalid_o <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Configuration registers; only byte lane 0 carries data

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			base_q[0] <= range_monitor_pkg::RST_BASE;
			base_q[1] <= range_monitor_pkg::RST_BASE;
			ctl_q[0]  <= range_monitor_pkg::RST_CTL;
			ctl_q[1]  <= range_monitor_pkg::RST_CTL;
			feature_q <= range_monitor_pkg::RST_FEATURE;
			irq_mask  <= range_monitor_pkg::RST_IRQ;
			for (int i = 0; i < range_monitor_pkg::EXT_COUNT; i++) begin
				ext_q[i] <= range_monitor_pkg::RST_EXT;
			end
		end else if (reg_wr) begin
			case (wdec[7:0])
				range_monitor_pkg::IDX_R1_BASE:  base_q[0] <= wdata_q[7:0];
				range_monitor_pkg::IDX_R1_CTL:   ctl_q[0]  <= wdata_q[7:0];
				range_monitor_pkg::IDX_R2_BASE:  base_q[1] <= wdata_q[7:0];
				range_monitor_pkg::IDX_R2_CTL:   ctl_q[1]  <= wdata_q[7:0];
				range_monitor_pkg::IDX_FEATURE:  feature_q <= wdata_q[7:0];
				range_monitor_pkg::IDX_IRQ_MASK: irq_mask  <= wdata_q[1:0];
				default: begin
					if (wdec[7:0] >= range_monitor_pkg::IDX_EXT_FIRST
						&& wdec[7:0] <= range_monitor_pkg::IDX_EXT_LAST) begin
						ext_q[3'(wdec[7:0] - range_monitor_pkg::IDX_EXT_FIRST)] <= wdata_q[7:0];
					end
				end
			endcase
		end
	end

	// Any extension write arms the fine decode until the next reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_written <= 1'b0;
		end else if (reg_wr && wdec[7:0] >= range_monitor_pkg::IDX_EXT_FIRST
			&& wdec[7:0] <= range_monitor_pkg::IDX_EXT_LAST) begin
			ext_written <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read channel

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= 32'h0000_0000;
			s_axi_rresp_o   <= range_monitor_pkg::RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b1;
			s_axi_rresp_o   <= rdec[8] ? range_monitor_pkg::RESP_OKAY : range_monitor_pkg::RESP_SLVERR;
			// Unmapped reads fall to the default and return zero
			case (rdec[7:0] & {8{rdec[8]}})
				range_monitor_pkg::IDX_R1_BASE:    s_axi_rdata_o <= {24'h00_0000, base_q[0]};
				range_monitor_pkg::IDX_R1_CTL:     s_axi_rdata_o <= {24'h00_0000, ctl_q[0]};
				range_monitor_pkg::IDX_R2_BASE:    s_axi_rdata_o <= {24'h00_0000, base_q[1]};
				range_monitor_pkg::IDX_R2_CTL:     s_axi_rdata_o <= {24'h00_0000, ctl_q[1]};
				range_monitor_pkg::IDX_FEATURE:    s_axi_rdata_o <= {24'h00_0000, feature_q};
				range_monitor_pkg::IDX_IRQ_STATUS: s_axi_rdata_o <= {30'h0000_0000, irq_status};
				range_monitor_pkg::IDX_IRQ_MASK:   s_axi_rdata_o <= {30'h0000_0000, irq_mask};
				default: begin
					if (rdec[8]) begin
						s_axi_rdata_o <= {24'h00_0000,
							ext_q[3'(rdec[7:0] - range_monitor_pkg::IDX_EXT_FIRST)]};
					end else begin
						s_axi_rdata_o <= 32'h0000_0000;
					end
				end
			endcase
		end else if (s_axi_rvalid_o && s_axi_rready_i) begin
			s_axi_rvalid_o  <= 1'b0;
			s_axi_arready_o <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Monitors

	for (genvar m = 0; m < 2; m++) begin : g_mon
		logic [63:0] pat;
		logic        mem_mode;

		assign mem_mode = feature_q[range_monitor_pkg::FEAT_MEM_BIT0 + m];
		assign pat = build(mem_mode, base_q[m], ctl_q[m],
			feature_q[range_monitor_pkg::FEAT_BASE_BIT0 + m],
			feature_q[range_monitor_pkg::FEAT_MASK_BIT0 + m], ext_written,
			ext_q[m * range_monitor_pkg::EXT_PER_MON],
			ext_q[m * range_monitor_pkg::EXT_PER_MON + 1],
			ext_q[m * range_monitor_pkg::EXT_PER_MON + 2],
			feature_q[range_monitor_pkg::FEAT_REMAP_BIT0 + m], io_upper_zero_i);

		range_match u_match (
			.want_i      (pat[63:32]),
			.care_i      (pat[31:0]),
			.mem_mode_i  (mem_mode),
			.rd_en_i     (ctl_q[m][range_monitor_pkg::CTL_RD_BIT]),
			.wr_en_i     (ctl_q[m][range_monitor_pkg::CTL_WR_BIT]),
			.cyc_valid_i (cyc_valid_i),
			.cyc_write_i (cyc_write_i),
			.cyc_mem_i   (cyc_mem_i),
			.cyc_cpu_i   (cyc_cpu_i),
			.cyc_addr_i  (cyc_addr_i),
			.match_o     (match[m])
		);
	end

	// One event per matching cycle, one output per monitor
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hit_q <= 2'h0;
		end else begin
			hit_q <= match;
		end
	end

	assign range_one_hit_event_o = hit_q[0];
	assign range_two_hit_event_o = hit_q[1];

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt status, write one to clear; a new event beats a clear

	assign w1c = (reg_wr && wdec[7:0] == range_monitor_pkg::IDX_IRQ_STATUS)
		? wdata_q[1:0] : 2'h0;
	assign next_irq_status = (irq_status & ~w1c) | hit_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_status <= range_monitor_pkg::RST_IRQ;
			irq_o      <= 1'b0;
		end else begin
			irq_status <= next_irq_status;
			irq_o      <= |(next_irq_status & irq_mask);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	a_hit_needs_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
		range_one_hit_event_o |-> $past(cyc_valid_i))
		else $error("hit without bus cycle");

	a_mem_cpu_only: assert property (@(posedge clk_i) disable iff (rst_i)
		range_two_hit_event_o && $past(cyc_mem_i) |-> $past(cyc_cpu_i))
		else $error("memory hit from non-CPU master");

	a_write_dir_gate: assert property (@(posedge clk_i) disable iff (rst_i)
		range_one_hit_event_o && $past(cyc_write_i) |-> $past(ctl_q[0][6]))
		else $error("write hit with write decode off");

	a_read_dir_gate: assert property (@(posedge clk_i) disable iff (rst_i)
		range_two_hit_event_o && !$past(cyc_write_i) |-> $past(ctl_q[1][5]))
		else $error("read hit with read decode off");

	a_feature_reset: assert property (@(posedge clk_i)
		$past(rst_i) |-> feature_q == range_monitor_pkg::RST_FEATURE)
		else $error("feature register reset value wrong");

	a_io_base_compare: assert property (@(posedge clk_i) disable iff (rst_i)
		range_one_hit_event_o && $past(!feature_q[4])
		|-> (($past(cyc_addr_i[8:1]) ^ $past(base_q[0])) & {3'h7, ~$past(ctl_q[0][4:0])}) == 8'h00)
		else $error("I/O hit disagrees with base");

	a_io_upper_ext: assert property (@(posedge clk_i) disable iff (rst_i)
		range_one_hit_event_o && $past(ext_written && !feature_q[4] && ext_q[1][5:0] == 6'h00)
		|-> $past(cyc_addr_i[15:10]) == $past(ext_q[0][5:0]))
		else $error("I/O upper bits ignored with extension on");

	a_ext_dormant: assert property (@(posedge clk_i) disable iff (rst_i)
		range_two_hit_event_o && $past(!ext_written && feature_q[5] && ctl_q[1][4:0] == 5'h00)
		|-> $past(cyc_addr_i[22:15]) == $past(base_q[1]))
		else $error("memory hit disagrees with base");

	a_status_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
		irq_status[0] && !w1c[0] |=> irq_status[0])
		else $error("status bit dropped without clear");

	a_bresp_holds: assert property (@(posedge clk_i) disable iff (rst_i)
		s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
		else $error("write response dropped early");

endmodule

`default_nettype wire

/* File: verif/host_cycle_model.sv */
// Host CPU bus cycle model: one I/O or memory cycle per call of run.
// Assumes the monitor samples each cycle at the rising edge of clk_i.

`default_nettype none

module host_cycle_model (
	// Clock
	input  wire logic        clk_i,
	// Bus cycle
	output var logic         cyc_valid_o,
	output var logic         cyc_write_o,
	output var logic         cyc_mem_o,
	output var logic         cyc_cpu_o,
	output var logic [31:0]  cyc_addr_o
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		cyc_valid_o = 1'b0;
		cyc_write_o = 1'b0;
		cyc_mem_o = 1'b0;
		cyc_cpu_o = 1'b0;
		cyc_addr_o = 32'h0000_0000;
	end

	// Qualifiers inverted between cycles so a stale value can never match
	task automatic run(input logic w, input logic m, input logic c, input logic [31:0] a);
		@(posedge clk_i);
		cyc_valid_o <= 1'b1;
		cyc_write_o <= w;
		cyc_mem_o <= m;
		cyc_cpu_o <= c;
		cyc_addr_o <= a;
		@(posedge clk_i);
		cyc_valid_o <= 1'b0;
		cyc_write_o <= ~w;
		cyc_mem_o <= ~m;
		cyc_cpu_o <= ~c;
		cyc_addr_o <= ~a;
	endtask

endmodule

`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking bench for the range access monitor.
// Assumes the host cycle model drives the bus cycle inputs.

`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [11:0] awaddr = '0;
	logic [11:0] araddr = '0;
	logic [31:0] wdata = '0;
	logic [3:0]  wstrb = '0;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        io_upper = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, irq, hit1, hit2;
	logic        valid, write, mem, cpu;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata, addr;
	int          fails = 0;
	int          compares = 0;

	range_access_monitor uut (
		.clk_i(clk_i), .rst_i(rst_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
		.cyc_valid_i(valid), .cyc_write_i(write), .cyc_mem_i(mem), .cyc_cpu_i(cpu),
		.cyc_addr_i(addr), .io_upper_zero_i(io_upper),
		.range_one_hit_event_o(hit1), .range_two_hit_event_o(hit2), .irq_o(irq)
	);

	host_cycle_model hm (
		.clk_i(clk_i), .cyc_valid_o(valid), .cyc_write_o(write), .cyc_mem_o(mem),
		.cyc_cpu_o(cpu), .cyc_addr_o(addr)
	);

	initial begin
		forever #20 clk_i = ~clk_i;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask

	task automatic stop_test();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic timeout();
		fails++;
		$display("unexpected wait: expected answer seen none");
		stop_test();
	endtask

	// Ready sampled at the falling edge: it stands until the next rising edge
	task automatic axi_wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] er);
		logic a, b, v;
		@(posedge clk_i);
		awaddr <= {2'b00, i, 2'b00};
		wdata <= {24'h00_0000, d};
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int n = 0; n < 40; n++) begin
			@(negedge clk_i);
			a = awvalid & awready;
			b = wvalid & wready;
			v = bvalid;
			if (v) chk("bresp", {30'h0, er}, {30'h0, bresp});
			@(posedge clk_i);
			if (a) awvalid <= 1'b0;
			if (b) wvalid <= 1'b0;
			if (v) begin
				bready <= 1'b0;
				return;
			end
		end
		timeout();
	endtask

	task automatic axi_rd(input logic [7:0] i, input logic [7:0] e, input logic [1:0] er);
		logic a, v;
		@(posedge clk_i);
		araddr <= {2'b00, i, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int n = 0; n < 40; n++) begin
			@(negedge clk_i);
			a = arvalid & arready;
			v = rvalid;
			if (v) chk("rdata", {24'h00_0000, e}, rdata);
			if (v) chk("rresp", {30'h0, er}, {30'h0, rresp});
			@(posedge clk_i);
			if (a) arvalid <= 1'b0;
			if (v) begin
				rready <= 1'b0;
				return;
			end
		end
		timeout();
	endtask

	// k = {write, memory, cpu}; e = {monitor two, monitor one}
	task automatic hit(input logic [2:0] k, input logic [31:0] a, input logic [1:0] e);
		hm.run(k[2], k[1], k[0], a);
		#1;
		chk("hit", {30'h0, e}, {30'h0, hit2, hit1});
		@(posedge clk_i);
		#1;
		chk("hit_end", 32'h0, {30'h0, hit2, hit1});
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		logic [7:0] ri [5] = '{8'h48, 8'h49, 8'hae, 8'hb8, 8'hb9};
		logic [7:0] rv [5] = '{8'h00, 8'h00, 8'h03, 8'h00, 8'h00};
		for (int k = 0; k < 5; k++) axi_rd(ri[k], rv[k], 2'h0);
		axi_wr(8'h10, 8'h5a, 2'h2);
		axi_rd(8'h10, 8'h00, 2'h2);
	endtask

	task automatic t_io();
		axi_wr(8'h48, 8'hf4, 2'h0);
		axi_wr(8'h49, 8'he3, 2'h0);
		axi_rd(8'h49, 8'he3, 2'h0);
		hit(3'b001, 32'h0000_03e8, 2'b01);
		hit(3'b101, 32'h0000_03ef, 2'b01);
		hit(3'b101, 32'h0000_03f0, 2'b00);
		hit(3'b101, 32'h0000_01e8, 2'b00);
		hit(3'b111, 32'h0000_03e8, 2'b00);
		axi_wr(8'h49, 8'hc3, 2'h0);
		hit(3'b001, 32'h0000_03e8, 2'b00);
	endtask

	task automatic t_mem();
		axi_wr(8'hb8, 8'h19, 2'h0);
		axi_wr(8'hb9, 8'h40, 2'h0);
		axi_wr(8'hae, 8'h29, 2'h0);
		hit(3'b111, 32'h000c_c000, 2'b10);
		hit(3'b111, 32'h000c_fffc, 2'b10);
		hit(3'b111, 32'h000d_0000, 2'b00);
		hit(3'b011, 32'h000c_c000, 2'b00);
		axi_wr(8'hb9, 8'h60, 2'h0);
		hit(3'b011, 32'h000c_c000, 2'b10);
		hit(3'b110, 32'h000c_c000, 2'b00);
		hit(3'b101, 32'h000c_c000, 2'b00);
		hit(3'b111, 32'h050c_c000, 2'b10);
	endtask

	task automatic t_irq();
		axi_wr(8'hc0, 8'h03, 2'h0);
		axi_wr(8'hc1, 8'h02, 2'h0);
		hit(3'b111, 32'h000c_c000, 2'b10);
		chk("irq", 32'h1, {31'h0, irq});
		axi_rd(8'hc0, 8'h02, 2'h0);
		axi_wr(8'hc0, 8'h02, 2'h0);
		axi_rd(8'hc0, 8'h00, 2'h0);
		chk("irq", 32'h0, {31'h0, irq});
		hit(3'b101, 32'h0000_03e8, 2'b01);
		axi_rd(8'hc0, 8'h01, 2'h0);
		chk("irq", 32'h0, {31'h0, irq});
	endtask

	task automatic t_ext();
		@(posedge clk_i);
		io_upper <= 1'b1;
		hit(3'b101, 32'h0000_07e8, 2'b00);
		hit(3'b101, 32'h0000_03e8, 2'b01);
		axi_wr(8'h70, 8'h01, 2'h0);
		for (int k = 1; k < 6; k++) axi_wr(8'h70 + 8'(k), 8'h00, 2'h0);
		hit(3'b101, 32'h0000_07e8, 2'b01);
		hit(3'b101, 32'h0000_03e8, 2'b00);
		hit(3'b111, 32'h000c_c000, 2'b10);
		hit(3'b111, 32'h000c_c004, 2'b00);
		axi_wr(8'h75, 8'h80, 2'h0);
		axi_wr(8'hae, 8'ha9, 2'h0);
		hit(3'b111, 32'h800c_c004, 2'b10);
		hit(3'b111, 32'h000c_c000, 2'b00);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_io();
		t_mem();
		t_irq();
		t_ext();
		stop_test();
	end

endmodule

`default_nettype wire
